// *** verilog/dfsp_top.sv ***
// Drive protection core: trips, fault lamps and stall-prevention frequency ramp
//
// Overview of operation
// R1 - Earth leak trips when one bus current sensor reads half or less of the other.
// R2 - Earth leak detection is off while the larger current is under 30 % of rated.
// R3 - Any active stall-prevention action makes the shared overload lamp blink.
// R4 - Current above 165 % of rated latches the overcurrent trip and lights its lamp.
// R5 - Bus voltage above the overvoltage threshold latches the overvoltage trip and lamp.
// R6 - A supply dropout longer than 15 ms and shorter than 80 ms lights the dropout lamp.
// R7 - A thermal overload trip lights the overcurrent and overvoltage lamps together.
// R8 - One lamp serves overload and overcurrent: steady for the trip, blinking for stall.
// R9 - In acceleration above 150 % current the ramp stops rising and falls at decel slope.
// R10 - When current drops to 150 % or below the ramp rises again at the accel slope.
// R11 - In deceleration with bus voltage over the stall level the frequency is held.
// R12 - At constant speed above 150 % current the frequency falls at decel slope.
// R13 - Motor current is checked against a thermal limit reduced at low speed.
// R14 - The thermal limit is rated current scaled by the percent setting.
// R15 - The largest setting equals 100 %, the rated current.
// R16 - Stall request and separate fault signals go out to the frequency controller.
// R17 - Trips stay latched until reset and the overload blink has a fixed period.
`timescale 1ns/1ps
`default_nettype none
`include "dfsp_map.svh"
module dfsp_top #(
  parameter int W = 12,
  parameter int FW = 16,
  parameter int IPF_MIN_CYC = `DFSP_IPF_MIN_MS * (`DFSP_CLK_HZ / 1000),
  parameter int IPF_MAX_CYC = `DFSP_IPF_MAX_MS * (`DFSP_CLK_HZ / 1000),
  parameter int BLINK_HALF_CYC = `DFSP_BLINK_HALF_MS * (`DFSP_CLK_HZ / 1000),
  parameter int RAMP_TICK_CYC = `DFSP_RAMP_TICK_CYC,
  parameter logic [31:0] THERM_TRIP_LEVEL = `DFSP_THERM_TRIP_LEVEL
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [W-1:0] BUS_CURRENT_SENSOR_A,
  input wire logic [W-1:0] BUS_CURRENT_SENSOR_B,
  input wire logic [W-1:0] RATED_CURRENT,
  input wire logic [W-1:0] BUS_VOLTAGE,
  input wire logic [W-1:0] OV_THRESHOLD,
  input wire logic [W-1:0] STALL_VOLT_LEVEL,
  input wire logic SUPPLY_LOST,
  input wire logic [6:0] THERMAL_LIMIT_SETTING,
  input wire logic [FW-1:0] THERMAL_KNEE_FREQ,
  input wire logic [FW-1:0] FREQ_TARGET,
  input wire logic [FW-1:0] ACCEL_STEP,
  input wire logic [FW-1:0] DECEL_STEP,
  output logic [FW-1:0] OUT_FREQ,
  output logic STALL_REQ,
  output dfsp_pkg::dfsp_stall_t STALL_STATE,
  output logic EARTH_LEAK_TRIP,
  output logic OVERLOAD_STALL_FLAG,
  output logic OVERCURRENT_TRIP,
  output logic OVERVOLTAGE_TRIP,
  output logic POWER_DROPOUT_FLAG,
  output logic THERMAL_TRIP,
  output logic LAMP_EARTH_LEAK,
  output logic LAMP_OVERLOAD_OC,
  output logic LAMP_OVERVOLTAGE,
  output logic LAMP_POWER_DROPOUT
);
  import dfsp_pkg::*;

  function automatic logic [W:0] pct_of(input logic [W-1:0] val, input logic [7:0] p);
    logic [W+7:0] prod;
    // Widen before multiplying so the product cannot wrap at the reading width
    prod = ({8'h00, val} * {{W{1'b0}}, p}) / (W+8)'(`DFSP_PCT_FULL);
    return prod[W:0];
  endfunction : pct_of

  logic [W-1:0] i_max;
  logic [W-1:0] i_min;
  logic over_stall_i;
  logic lost_meta;
  logic lost_sync;
  logic lost_prev;
  logic [31:0] lost_cnt;
  logic [31:0] blink_cnt;
  logic blink_phase;
  logic [31:0] tick_cnt;
  logic tick;
  logic any_trip;
  logic accelerating;
  logic decelerating;
  dfsp_stall_t stall;
  logic [FW:0] freq_up;
  logic [FW-1:0] freq_down;

  dfsp_thermal_if #(.W(W), .FW(FW)) th_link ();

  assign i_max = (BUS_CURRENT_SENSOR_A >= BUS_CURRENT_SENSOR_B) ? BUS_CURRENT_SENSOR_A
               : BUS_CURRENT_SENSOR_B;
  assign i_min = (BUS_CURRENT_SENSOR_A >= BUS_CURRENT_SENSOR_B) ? BUS_CURRENT_SENSOR_B
               : BUS_CURRENT_SENSOR_A;
  assign over_stall_i = {1'b0, i_max} > pct_of(RATED_CURRENT, `DFSP_STALL_PCT);
  assign any_trip = EARTH_LEAK_TRIP | OVERCURRENT_TRIP | OVERVOLTAGE_TRIP | THERMAL_TRIP;

  assign th_link.current = i_max;
  assign th_link.rated = RATED_CURRENT;
  assign th_link.setting = THERMAL_LIMIT_SETTING;
  assign th_link.freq = OUT_FREQ;
  assign th_link.knee = THERMAL_KNEE_FREQ;

  dfsp_thermal #(.W(W), .FW(FW), .TRIP_LEVEL(THERM_TRIP_LEVEL)) u_thermal (
    .clk(CLK),
    .reset(RESET),
    .th(th_link.relay)
  );

  assign THERMAL_TRIP = th_link.trip;

  // Trip latches hold until reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      EARTH_LEAK_TRIP <= 1'b0;
    end else if ({1'b0, i_max} >= pct_of(RATED_CURRENT, `DFSP_GF_MIN_PCT) // see R2
                 && {1'b0, i_min, 1'b0} <= {1'b0, 1'b0, i_max}) begin
      EARTH_LEAK_TRIP <= 1'b1; // see R1, R17
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      OVERCURRENT_TRIP <= 1'b0;
    end else if ({1'b0, i_max} > pct_of(RATED_CURRENT, `DFSP_OC_TRIP_PCT)) begin
      OVERCURRENT_TRIP <= 1'b1; // see R4, R17
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      OVERVOLTAGE_TRIP <= 1'b0;
    end else if (BUS_VOLTAGE > OV_THRESHOLD) begin
      OVERVOLTAGE_TRIP <= 1'b1; // see R5, R17
    end
  end

  // Dropout pin is asynchronous to the core
  always_ff @(posedge CLK) begin
    if (RESET) begin
      lost_meta <= 1'b0;
      lost_sync <= 1'b0;
      lost_prev <= 1'b0;
    end else begin
      lost_meta <= SUPPLY_LOST;
      lost_sync <= lost_meta;
      lost_prev <= lost_sync;
    end
  end

  // Counter saturates at the upper bound so very long outages never qualify
  always_ff @(posedge CLK) begin
    if (RESET) begin
      lost_cnt <= '0;
    end else if (!lost_sync) begin
      lost_cnt <= '0;
    end else if (lost_cnt < 32'(IPF_MAX_CYC)) begin
      lost_cnt <= lost_cnt + 32'h00000001;
    end
  end

  // Judged when the supply returns, since the length is known only then
  always_ff @(posedge CLK) begin
    if (RESET) begin
      POWER_DROPOUT_FLAG <= 1'b0;
    end else if (lost_prev && !lost_sync && lost_cnt > 32'(IPF_MIN_CYC)
                 && lost_cnt < 32'(IPF_MAX_CYC)) begin
      POWER_DROPOUT_FLAG <= 1'b1; // see R6, R17
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= '0;
      blink_phase <= ~blink_phase; // see R17
    end else begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(RAMP_TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  assign accelerating = OUT_FREQ < FREQ_TARGET;
  assign decelerating = OUT_FREQ > FREQ_TARGET;

  always_ff @(posedge CLK) begin
    if (RESET || any_trip) begin
      stall <= STALL_NONE;
    end else begin
      unique case (stall)
        STALL_NONE: begin
          if (accelerating && over_stall_i) begin
            stall <= STALL_ACCEL; // see R9
          end else if (decelerating && BUS_VOLTAGE > STALL_VOLT_LEVEL) begin
            stall <= STALL_DECEL; // see R11
          end else if (!accelerating && !decelerating && over_stall_i) begin
            stall <= STALL_CONST; // see R12
          end
        end
        STALL_ACCEL: begin
          if (!over_stall_i) begin
            stall <= STALL_NONE; // see R10
          end
        end
        STALL_DECEL: begin
          if (BUS_VOLTAGE <= STALL_VOLT_LEVEL) begin
            stall <= STALL_NONE; // see R11
          end
        end
        STALL_CONST: begin
          if (!over_stall_i) begin
            stall <= STALL_NONE; // see R12
          end
        end
      endcase
    end
  end

  assign freq_up = {1'b0, OUT_FREQ} + {1'b0, ACCEL_STEP};
  assign freq_down = (OUT_FREQ > DECEL_STEP) ? OUT_FREQ - DECEL_STEP : '0;

  // A tripped drive has its output removed
  always_ff @(posedge CLK) begin
    if (RESET || any_trip) begin
      OUT_FREQ <= '0;
    end else if (tick) begin
      unique case (stall)
        STALL_ACCEL, STALL_CONST: begin
          OUT_FREQ <= freq_down; // see R9, R12
        end
        STALL_DECEL: begin
          OUT_FREQ <= OUT_FREQ; // see R11
        end
        STALL_NONE: begin
          if (accelerating) begin
            OUT_FREQ <= (freq_up > {1'b0, FREQ_TARGET}) ? FREQ_TARGET
                      : freq_up[FW-1:0]; // see R10
          end else if (decelerating) begin
            OUT_FREQ <= (freq_down < FREQ_TARGET) ? FREQ_TARGET : freq_down;
          end
        end
      endcase
    end
  end

  assign STALL_STATE = stall;
  assign STALL_REQ = stall != STALL_NONE; // see R16
  assign OVERLOAD_STALL_FLAG = STALL_REQ; // see R16
  assign LAMP_EARTH_LEAK = EARTH_LEAK_TRIP;
  // Steady trip outranks blink on the shared lamp
  assign LAMP_OVERLOAD_OC = OVERCURRENT_TRIP | THERMAL_TRIP
                          | (STALL_REQ & blink_phase); // see R3, R7, R8
  assign LAMP_OVERVOLTAGE = OVERVOLTAGE_TRIP | THERMAL_TRIP; // see R7
  assign LAMP_POWER_DROPOUT = POWER_DROPOUT_FLAG;
endmodule : dfsp_top
`default_nettype wire

// *** verilog/dfsp_map.svh ***
// Offsets-free constant map: thresholds, percentages and timing for drive protection
`ifndef DFSP_MAP_SVH
`define DFSP_MAP_SVH

`define DFSP_CLK_HZ 100000000
`define DFSP_PCT_FULL 8'd100
`define DFSP_GF_MIN_PCT 8'd30
`define DFSP_OC_TRIP_PCT 8'd165
`define DFSP_STALL_PCT 8'd150
`define DFSP_SETTING_MAX 7'd100
`define DFSP_IPF_MIN_MS 15
`define DFSP_IPF_MAX_MS 80
`define DFSP_BLINK_HALF_MS 250
`define DFSP_RAMP_TICK_CYC 1000
`define DFSP_DERATE_MIN_PCT 8'd50
`define DFSP_THERM_LEAK 8'd1
`define DFSP_THERM_TRIP_LEVEL 32'h05F5E100

`endif

// *** verilog/dfsp_pkg.sv ***
// Types shared by the drive protection block
package dfsp_pkg;
  typedef enum logic [1:0] {
    STALL_NONE,
    STALL_ACCEL,
    STALL_DECEL,
    STALL_CONST
  } dfsp_stall_t;
endpackage : dfsp_pkg

// *** verilog/dfsp_thermal_if.sv ***
// Link between the protection core and the electronic thermal relay
`timescale 1ns/1ps
`default_nettype none
interface dfsp_thermal_if #(parameter int W = 12, parameter int FW = 16);
  logic [W-1:0] current;
  logic [W-1:0] rated;
  logic [6:0] setting;
  logic [FW-1:0] freq;
  logic [FW-1:0] knee;
  logic trip;
  modport feed (output current, output rated, output setting, output freq, output knee,
    input trip);
  modport relay (input current, input rated, input setting, input freq, input knee,
    output trip);
endinterface : dfsp_thermal_if
`default_nettype wire

// *** verilog/dfsp_thermal.sv ***
// Electronic thermal relay: speed-derated current limit and heat accumulator
`timescale 1ns/1ps
`default_nettype none
`include "dfsp_map.svh"
module dfsp_thermal #(
  parameter int W = 12,
  parameter int FW = 16,
  parameter int ACC_W = 32,
  parameter logic [31:0] TRIP_LEVEL = `DFSP_THERM_TRIP_LEVEL
) (
  input wire logic clk,
  input wire logic reset,
  dfsp_thermal_if.relay th
);
  import dfsp_pkg::*;

  logic [6:0] setting_clamped;
  logic [W+7:0] base_limit;
  logic [7:0] derate_pct;
  logic [W+15:0] limit_wide;
  logic [W:0] limit;
  logic [ACC_W-1:0] heat;
  logic trip;

  // Full-scale position and 100 % are the same point
  assign setting_clamped = (th.setting > `DFSP_SETTING_MAX) ? `DFSP_SETTING_MAX
                         : th.setting; // see R15
  // Operands widened first so the product cannot wrap at the reading width
  assign base_limit = ({8'h00, th.rated} * {{(W+1){1'b0}}, setting_clamped})
                    / (W+8)'(`DFSP_PCT_FULL); // see R14

  // Linear derating below the knee; fan cooling drops with speed
  always_comb begin
    logic [FW+7:0] span;
    span = '0;
    if (th.freq >= th.knee || th.knee == '0) begin
      derate_pct = `DFSP_PCT_FULL;
    end else begin
      span = ((FW+8)'(`DFSP_PCT_FULL - `DFSP_DERATE_MIN_PCT) * {8'h00, th.freq})
             / {8'h00, th.knee};
      derate_pct = `DFSP_DERATE_MIN_PCT + span[7:0]; // see R13
    end
  end

  assign limit_wide = ({8'h00, base_limit} * {{(W+8){1'b0}}, derate_pct})
                    / (W+16)'(`DFSP_PCT_FULL);
  assign limit = limit_wide[W:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      heat <= '0;
    end else if ({1'b0, th.current} > limit) begin
      // Saturate rather than wrap so a long overload cannot look cool
      if (heat > ~ACC_W'({1'b0, th.current} - limit)) begin
        heat <= '1;
      end else begin
        heat <= heat + ACC_W'({1'b0, th.current} - limit); // see R13
      end
    end else if (heat > ACC_W'(`DFSP_THERM_LEAK)) begin
      heat <= heat - ACC_W'(`DFSP_THERM_LEAK);
    end else begin
      heat <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trip <= 1'b0;
    end else if (32'(heat) >= TRIP_LEVEL) begin
      trip <= 1'b1; // see R17
    end
  end

  assign th.trip = trip;
endmodule : dfsp_thermal
`default_nettype wire

// *** test/dfsp_top_asserts.sv ***
// Concurrent checks on the drive protection core ports
`timescale 1ns/1ps
`default_nettype none
module dfsp_top_chk #(parameter int W = 12, parameter int FW = 16) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [W-1:0] BUS_CURRENT_SENSOR_A,
  input wire logic [W-1:0] BUS_CURRENT_SENSOR_B,
  input wire logic [W-1:0] RATED_CURRENT,
  input wire logic [W-1:0] BUS_VOLTAGE,
  input wire logic [W-1:0] OV_THRESHOLD,
  input wire logic [FW-1:0] OUT_FREQ,
  input wire logic STALL_REQ,
  input wire dfsp_pkg::dfsp_stall_t STALL_STATE,
  input wire logic EARTH_LEAK_TRIP,
  input wire logic OVERLOAD_STALL_FLAG,
  input wire logic OVERCURRENT_TRIP,
  input wire logic OVERVOLTAGE_TRIP,
  input wire logic POWER_DROPOUT_FLAG,
  input wire logic THERMAL_TRIP,
  input wire logic LAMP_OVERLOAD_OC,
  input wire logic LAMP_OVERVOLTAGE
);
  import dfsp_pkg::*;
  logic [W-1:0] imax;
  logic [W-1:0] imin;
  logic [19:0] r30;
  logic [19:0] r165;
  logic leak_c;
  logic oc_c;
  logic trip;
  assign imax = (BUS_CURRENT_SENSOR_A > BUS_CURRENT_SENSOR_B) ? BUS_CURRENT_SENSOR_A :
    BUS_CURRENT_SENSOR_B;
  assign imin = (BUS_CURRENT_SENSOR_A > BUS_CURRENT_SENSOR_B) ? BUS_CURRENT_SENSOR_B :
    BUS_CURRENT_SENSOR_A;
  assign r30 = RATED_CURRENT * 20'h1E / 20'h64;
  assign r165 = RATED_CURRENT * 20'hA5 / 20'h64;
  assign leak_c = (imax >= r30) && ({imin, 1'b0} <= {1'b0, imax});
  assign oc_c = imax > r165;
  assign trip = EARTH_LEAK_TRIP || OVERCURRENT_TRIP || OVERVOLTAGE_TRIP || THERMAL_TRIP;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  a_leak_trip: assert property (leak_c |=> EARTH_LEAK_TRIP)
    else $error("earth leak not set");
  a_leak_cause: assert property ($rose(EARTH_LEAK_TRIP) |-> $past(leak_c))
    else $error("earth leak without cause");
  a_oc_trip: assert property (oc_c |=> OVERCURRENT_TRIP)
    else $error("overcurrent not set");
  a_oc_cause: assert property ($rose(OVERCURRENT_TRIP) |-> $past(oc_c))
    else $error("overcurrent without cause");
  a_ov_trip: assert property (BUS_VOLTAGE > OV_THRESHOLD |=> OVERVOLTAGE_TRIP)
    else $error("overvoltage not set");
  a_trips_sticky: assert property (!($fell(EARTH_LEAK_TRIP) || $fell(OVERCURRENT_TRIP) ||
    $fell(OVERVOLTAGE_TRIP) || $fell(POWER_DROPOUT_FLAG) || $fell(THERMAL_TRIP)))
    else $error("trip flag cleared");
  a_lamp_ov: assert property (LAMP_OVERVOLTAGE == (OVERVOLTAGE_TRIP || THERMAL_TRIP))
    else $error("overvoltage lamp wrong");
  a_lamp_steady: assert property (OVERCURRENT_TRIP || THERMAL_TRIP |-> LAMP_OVERLOAD_OC)
    else $error("overcurrent lamp dark");
  a_lamp_cause: assert property (LAMP_OVERLOAD_OC |-> OVERCURRENT_TRIP || THERMAL_TRIP || STALL_REQ)
    else $error("overload lamp without cause");
  a_stall_flag: assert property (STALL_REQ == (STALL_STATE != STALL_NONE) &&
    OVERLOAD_STALL_FLAG == STALL_REQ)
    else $error("stall request mismatch");
  a_trip_stop: assert property (trip |=> OUT_FREQ == 16'h0 && STALL_STATE == STALL_NONE)
    else $error("ramp runs after trip");
  a_decel_hold: assert property (STALL_STATE == STALL_DECEL && !trip |=> $stable(OUT_FREQ))
    else $error("frequency moved in decel stall");
  a_no_rise: assert property (STALL_STATE inside {STALL_ACCEL, STALL_CONST} |=>
    OUT_FREQ <= $past(OUT_FREQ))
    else $error("frequency rose in stall");
  c_leak: cover property ($rose(EARTH_LEAK_TRIP));
  c_accel: cover property (STALL_STATE == STALL_ACCEL);
  c_decel: cover property (STALL_STATE == STALL_DECEL);
  c_drop: cover property ($rose(POWER_DROPOUT_FLAG));
endmodule : dfsp_top_chk
bind dfsp_top dfsp_top_chk #(.W(W), .FW(FW)) u_dfsp_top_chk (.*);
`default_nettype wire

// *** test/dfsp_sense_model.sv ***
// Model of the current sensors and the supply-loss detector
`timescale 1ns/1ps
`default_nettype none
module dfsp_sense_model (
  input wire logic clk,
  input wire logic [11:0] amps,
  input wire logic leak,
  output logic [11:0] sense_a,
  output logic [11:0] sense_b,
  output logic lost
);
  initial lost = 1'b0;
  assign sense_a = amps;
  // A grounded lead returns only a third on the second sensor
  assign sense_b = leak ? amps / 12'h3 : amps;
  task automatic outage(input int n);
    @(negedge clk);
    lost = 1'b1;
    repeat (n) @(negedge clk);
    lost = 1'b0;
  endtask : outage
endmodule : dfsp_sense_model
`default_nettype wire

// *** test/drive_fault_stall_protect_bench.sv ***
// Self-checking bench for the drive protection core
`timescale 1ns/1ps
`default_nettype none
module drive_fault_stall_protect_bench;
  import dfsp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] amps = 12'h0;
  logic leak = 1'b0;
  logic [11:0] volt = 12'h0;
  logic [15:0] knee = 16'h0;
  logic [15:0] target = 16'h0;
  logic [11:0] rated = 12'h64;
  logic [11:0] ov_lvl = 12'h320;
  logic [11:0] stall_lvl = 12'h258;
  logic [6:0] th_set = 7'h7F;
  logic [15:0] acc_step = 16'hA;
  logic [15:0] dec_step = 16'h5;
  logic [11:0] sa, sb;
  logic [15:0] freq;
  logic lost, req, el, ol, oc, ov, pd, tt, l_el, l_oc, l_ov, l_pd;
  dfsp_stall_t st;
  int error_cnt = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  dfsp_sense_model u_dfsp_sense_model (.clk(clk), .amps(amps), .leak(leak), .sense_a(sa),
    .sense_b(sb), .lost(lost));
  dfsp_top #(.IPF_MIN_CYC(20), .IPF_MAX_CYC(80), .BLINK_HALF_CYC(8), .RAMP_TICK_CYC(4),
    .THERM_TRIP_LEVEL(32'h1000)) u_dfsp_top (.CLK(clk), .RESET(reset),
    .BUS_CURRENT_SENSOR_A(sa), .BUS_CURRENT_SENSOR_B(sb), .RATED_CURRENT(rated),
    .BUS_VOLTAGE(volt), .OV_THRESHOLD(ov_lvl), .STALL_VOLT_LEVEL(stall_lvl),
    .SUPPLY_LOST(lost), .THERMAL_LIMIT_SETTING(th_set), .THERMAL_KNEE_FREQ(knee),
    .FREQ_TARGET(target), .ACCEL_STEP(acc_step), .DECEL_STEP(dec_step), .OUT_FREQ(freq),
    .STALL_REQ(req), .STALL_STATE(st), .EARTH_LEAK_TRIP(el), .OVERLOAD_STALL_FLAG(ol),
    .OVERCURRENT_TRIP(oc), .OVERVOLTAGE_TRIP(ov), .POWER_DROPOUT_FLAG(pd),
    .THERMAL_TRIP(tt), .LAMP_EARTH_LEAK(l_el), .LAMP_OVERLOAD_OC(l_oc),
    .LAMP_OVERVOLTAGE(l_ov), .LAMP_POWER_DROPOUT(l_pd));
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic rst();
    @(negedge clk);
    reset = 1'b1;
    amps = 12'h0;
    leak = 1'b0;
    volt = 12'h0;
    target = 16'h0;
    knee = 16'h0;
    th_set = 7'h7F;
    cyc(2);
    chk(freq === 16'h0 && st === STALL_NONE && {el, oc, ov, pd, tt} === 5'h0, "reset");
    reset = 1'b0;
  endtask : rst
  task automatic t_leak();
    rst();
    amps = 12'h14;
    leak = 1'b1;
    cyc(5);
    chk(el === 1'b0, "leak below floor");
    amps = 12'h64;
    cyc(2);
    chk(el === 1'b1 && l_el === 1'b1, "leak trip");
  endtask : t_leak
  task automatic t_oc();
    rst();
    amps = 12'hA5;
    cyc(3);
    chk(oc === 1'b0 && el === 1'b0, "overcurrent at limit");
    amps = 12'hA6;
    cyc(2);
    chk(oc === 1'b1, "overcurrent trip");
    amps = 12'h0;
    repeat (20) begin
      cyc(1);
      chk(l_oc === 1'b1 && oc === 1'b1, "overcurrent lamp steady");
    end
  endtask : t_oc
  task automatic t_ov();
    rst();
    volt = 12'h320;
    cyc(3);
    chk(ov === 1'b0, "overvoltage at limit");
    volt = 12'h321;
    cyc(2);
    chk(ov === 1'b1 && l_ov === 1'b1 && l_oc === 1'b0, "overvoltage trip");
  endtask : t_ov
  task automatic t_drop(input int n, input logic e);
    rst();
    u_dfsp_sense_model.outage(n);
    cyc(6);
    chk(pd === e && l_pd === e, "dropout flag");
  endtask : t_drop
  task automatic t_accel();
    logic [15:0] f;
    logic s0, s1;
    rst();
    target = 16'h3E8;
    amps = 12'h64;
    cyc(40);
    amps = 12'hA0;
    cyc(2);
    chk(st === STALL_ACCEL && req === 1'b1 && ol === 1'b1, "accel stall");
    f = freq;
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (20) begin
      cyc(1);
      s0 |= (l_oc === 1'b0);
      s1 |= (l_oc === 1'b1);
    end
    chk(s0 && s1 && oc === 1'b0, "stall blink");
    chk(freq === f - 16'h19, "accel stall slope");
    amps = 12'h64;
    cyc(2);
    f = freq;
    chk(st === STALL_NONE, "accel stall ends");
    cyc(20);
    chk(freq === f + 16'h32, "accel resumes");
  endtask : t_accel
  task automatic t_const();
    logic [15:0] f;
    rst();
    target = 16'h32;
    amps = 12'h64;
    cyc(40);
    chk(freq === 16'h32, "ramp at target");
    amps = 12'hA0;
    cyc(2);
    f = freq;
    chk(st === STALL_CONST, "const stall");
    cyc(8);
    chk(freq === f - 16'hA, "const stall slope");
    amps = 12'h64;
    cyc(20);
    volt = 12'h2BC;
    target = 16'h0;
    cyc(2);
    f = freq;
    chk(st === STALL_DECEL, "decel stall");
    cyc(20);
    chk(freq === f, "decel hold");
    volt = 12'h0;
    cyc(50);
    chk(freq === 16'h0 && st === STALL_NONE, "decel done");
  endtask : t_const
  task automatic t_therm();
    int i;
    rst();
    amps = 12'h5A;
    cyc(150);
    chk(tt === 1'b0, "full limit at speed");
    knee = 16'h3E8;
    for (i = 0; i < 200 && tt !== 1'b1; i++) cyc(1);
    chk(tt === 1'b1 && l_oc === 1'b1 && l_ov === 1'b1 && {oc, ov} === 2'h0, "thermal");
    if (i == 200) test_done();
  endtask : t_therm
  // Half setting halves the limit, so the current that was safe above now trips
  task automatic t_scale();
    int i;
    rst();
    th_set = 7'h32;
    amps = 12'h5A;
    for (i = 0; i < 200 && tt !== 1'b1; i++) cyc(1);
    chk(tt === 1'b1 && l_oc === 1'b1 && l_ov === 1'b1, "thermal setting scale");
    if (i == 200) test_done();
  endtask : t_scale
  initial begin
    t_leak();
    t_oc();
    t_ov();
    t_drop(10, 1'b0);
    t_drop(50, 1'b1);
    t_drop(120, 1'b0);
    t_accel();
    t_const();
    t_therm();
    t_scale();
    test_done();
  end
endmodule : drive_fault_stall_protect_bench
`default_nettype wire
